// [common/dmx_regs.vh]
`ifndef DMX_REGS_VH
`define DMX_REGS_VH
// Register offsets, as printed; the register port is 12 bits wide.
`define DMX_ADDR_W 12
`define DMX_OFS_DAC_ST_GAIN 12'h600
`define DMX_OFS_DAC_LEFT_ROUTING 12'h601
`define DMX_OFS_DAC_RIGHT_ROUTING 12'h602
`define DMX_OFS_SEC_TX_ST_GAIN 12'h603
`define DMX_OFS_SEC_TX_LEFT_ROUTING 12'h604
`define DMX_OFS_SEC_TX_RIGHT_ROUTING 12'h605
`define DMX_OFS_PRI_TX_LEFT_ROUTING 12'h606
`define DMX_OFS_PRI_TX_RIGHT_ROUTING 12'h607
`define DMX_OFS_SIDETONE_FILTER 12'h621
`define DMX_OFS_CAPTURE_CONFIG 12'h622
`define DMX_OFS_CLIP_STATUS 12'h623
// Gain fields in both sidetone gain registers.
`define DMX_RIGHT_GAIN_MSB 8
`define DMX_RIGHT_GAIN_LSB 5
`define DMX_LEFT_GAIN_MSB 3
`define DMX_LEFT_GAIN_LSB 0
`define DMX_GAIN_RESET 4'h0
// Output mixer routing bits.
`define DMX_BIT_ST_RIGHT_EN 5
`define DMX_BIT_ST_LEFT_EN 4
`define DMX_BIT_SEC_RX_EN 2
`define DMX_BIT_PRI_RX_EN 0
`define DMX_BIT_CAPTURE_EN 1
`define DMX_BIT_SEC_TO_PRI_EN 0
`define DMX_ROUTING_RESET 6'h00
// Sidetone filter control.
`define DMX_BIT_HPF_EN 6
`define DMX_CUT_MSB 9
`define DMX_CUT_LSB 7
`define DMX_FILTER_RESET 4'h0
`define DMX_CUT_RESERVED 3'h7
`define DMX_CUT_LAST 3'h6
`define DMX_HPF_BASE_SHIFT 4'h2
// Capture configuration bits.
`define DMX_BIT_LEFT_CONV_EN 0
`define DMX_BIT_RIGHT_CONV_EN 1
`define DMX_BIT_CLK_SRC 2
`define DMX_CONFIG_RESET 3'h0
// Gain coefficients, unsigned Q1.15, 0 dB is 1.0.
`define DMX_COEF_FRAC 15
`define DMX_COEF_0DB 16'h8000
`endif

// [design/dmx_gain.v]
`timescale 1ns/10ps
`default_nettype none
`include "dmx_regs.vh"
// Applies a 4-bit sidetone gain code to one sample, registered.
module dmx_gain #(
   parameter DW = 24
) (
   input wire clock,
   input wire resetn,
   input wire [3:0] gain_code,
   input wire signed [DW-1:0] sample_in,
   output reg signed [DW-1:0] sample_out
);
   wire [15:0] coef;
   wire signed [DW+16:0] product;

   // Maps the code to a linear factor in 3 dB steps, top codes held at 0 dB.
   function [15:0] gain_coef;
      input [3:0] code;
      begin
         case (code)
            4'h0: gain_coef = 16'h0207;
            4'h1: gain_coef = 16'h02DE;
            4'h2: gain_coef = 16'h040C;
            4'h3: gain_coef = 16'h05B8;
            4'h4: gain_coef = 16'h0814;
            4'h5: gain_coef = 16'h0B68;
            4'h6: gain_coef = 16'h101D;
            4'h7: gain_coef = 16'h16C3;
            4'h8: gain_coef = 16'h2027;
            4'h9: gain_coef = 16'h2D6B;
            4'hA: gain_coef = 16'h4027;
            4'hB: gain_coef = 16'h5A9E;
            default: gain_coef = `DMX_COEF_0DB;
         endcase
      end
   endfunction

   assign coef = gain_coef(gain_code);
   assign product = sample_in * $signed({1'b0, coef});

   // Scales the sample; the factor never exceeds one, so no overflow.
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         sample_out <= {DW{1'b0}};
      end else begin
         sample_out <= product[DW+`DMX_COEF_FRAC-1:`DMX_COEF_FRAC];
      end
   end
endmodule
`default_nettype wire

// [design/dmx_dc_filter.v]
`timescale 1ns/10ps
`default_nettype none
`include "dmx_regs.vh"
// First-order DC-removal filter that advances once per sample strobe.
module dmx_dc_filter #(
   parameter DW = 24
) (
   input wire clock,
   input wire resetn,
   input wire step,
   input wire enable,
   input wire [2:0] cutoff,
   input wire signed [DW-1:0] sample_in,
   output reg signed [DW-1:0] sample_out
);
   localparam AW = DW + 4;
   reg signed [DW-1:0] prev_in;
   reg signed [AW-1:0] acc;
   wire [2:0] cut_eff;
   wire [3:0] shift;
   wire signed [AW-1:0] next_acc;
   wire signed [AW-1:0] max_v;
   wire signed [AW-1:0] min_v;

   // The reserved code acts as the lowest cut-off; each step halves it.
   assign cut_eff = (cutoff == `DMX_CUT_RESERVED) ? `DMX_CUT_LAST : cutoff;
   assign shift = `DMX_HPF_BASE_SHIFT + {1'b0, cut_eff};
   assign next_acc = sample_in - prev_in + acc - (acc >>> shift);
   assign max_v = {{5{1'b0}}, {(DW-1){1'b1}}};
   assign min_v = ~max_v;

   // Filter state moves only on the selected port's strobe, so the corner
   // tracks that port's sample rate.
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         prev_in <= {DW{1'b0}};
         acc <= {AW{1'b0}};
         sample_out <= {DW{1'b0}};
      end else begin
         if (step) begin
            prev_in <= sample_in;
            acc <= enable ? next_acc : {AW{1'b0}};
         end
         if (!enable) begin
            sample_out <= sample_in;
         end else if (acc > max_v) begin
            sample_out <= max_v[DW-1:0];
         end else if (acc < min_v) begin
            sample_out <= min_v[DW-1:0];
         end else begin
            sample_out <= acc[DW-1:0];
         end
      end
   end
endmodule
`default_nettype wire

// [design/dmx_mixer.v]
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "dmx_regs.vh"
module dmx_mixer #(
   parameter DW = 24
) (
   input wire clock,
   input wire resetn,
   input wire [11:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   output reg [15:0] reg_rdata,
   input wire primary_frame_strobe,
   input wire secondary_frame_strobe,
   input wire signed [DW-1:0] left_adc_data,
   input wire signed [DW-1:0] right_adc_data,
   input wire signed [DW-1:0] left_digital_microphone_input,
   input wire signed [DW-1:0] right_digital_microphone_input,
   input wire signed [DW-1:0] primary_rx_left,
   input wire signed [DW-1:0] primary_rx_right,
   input wire signed [DW-1:0] secondary_rx_left,
   input wire signed [DW-1:0] secondary_rx_right,
   output reg signed [DW-1:0] primary_tx_left,
   output reg signed [DW-1:0] primary_tx_right,
   output reg signed [DW-1:0] dac_left,
   output reg signed [DW-1:0] dac_right,
   output reg signed [DW-1:0] secondary_tx_left,
   output reg signed [DW-1:0] secondary_tx_right
);
   localparam SW = DW + 3;

   // Register state.
   reg [3:0] left_sidetone_to_dac_gain;
   reg [3:0] right_sidetone_to_dac_gain;
   reg [3:0] left_sidetone_to_sec_tx_gain;
   reg [3:0] right_sidetone_to_sec_tx_gain;
   reg [5:0] dac_left_routing;
   reg [5:0] dac_right_routing;
   reg [5:0] sec_tx_left_routing;
   reg [5:0] sec_tx_right_routing;
   reg left_capture_to_primary_tx_en;
   reg secondary_left_to_primary_tx_en;
   reg right_capture_to_primary_tx_en;
   reg secondary_right_to_primary_tx_en;
   reg sidetone_dc_filter_en;
   reg [2:0] sidetone_filter_cutoff;
   reg left_converter_enable;
   reg right_converter_enable;
   reg core_clock_source_sel;
   reg [5:0] clip_status;
   reg [15:0] next_rdata;

   // Datapath state.
   reg signed [DW-1:0] left_capture;
   reg signed [DW-1:0] right_capture;
   wire signed [DW-1:0] left_sidetone;
   wire signed [DW-1:0] right_sidetone;
   wire signed [DW-1:0] left_st_dac;
   wire signed [DW-1:0] right_st_dac;
   wire signed [DW-1:0] left_st_sec;
   wire signed [DW-1:0] right_st_sec;
   wire filter_step;
   wire signed [SW-1:0] sum_pri_l;
   wire signed [SW-1:0] sum_pri_r;
   wire signed [SW-1:0] sum_dac_l;
   wire signed [SW-1:0] sum_dac_r;
   wire signed [SW-1:0] sum_sec_l;
   wire signed [SW-1:0] sum_sec_r;
   wire [5:0] clip_now;
   wire [5:0] clip_clear;
   wire wr_clip;

   // Passes a term into a sum only while its enable is set.
   function signed [SW-1:0] term;
      input en;
      input signed [DW-1:0] x;
      begin
         term = en ? {{3{x[DW-1]}}, x} : {SW{1'b0}};
      end
   endfunction

   // Sums one output mixer: two port terms and both sidetones.
   function signed [SW-1:0] mix4;
      input [5:0] rt;
      input signed [DW-1:0] pri;
      input signed [DW-1:0] sec;
      input signed [DW-1:0] st_l;
      input signed [DW-1:0] st_r;
      begin
         mix4 = term(rt[`DMX_BIT_PRI_RX_EN], pri) + term(rt[`DMX_BIT_SEC_RX_EN], sec)
            + term(rt[`DMX_BIT_ST_LEFT_EN], st_l) + term(rt[`DMX_BIT_ST_RIGHT_EN], st_r);
      end
   endfunction

   // Limits a wide sum to the sample range.
   function signed [DW-1:0] sat;
      input signed [SW-1:0] s;
      begin
         if (s[SW-1] == 1'b0 && s[SW-2:DW-1] != {(SW-DW){1'b0}}) begin
            sat = {1'b0, {(DW-1){1'b1}}};
         end else if (s[SW-1] == 1'b1 && s[SW-2:DW-1] != {(SW-DW){1'b1}}) begin
            sat = {1'b1, {(DW-1){1'b0}}};
         end else begin
            sat = s[DW-1:0];
         end
      end
   endfunction

   // Flags a sum that saturation had to limit.
   function clipped;
      input signed [SW-1:0] s;
      begin
         clipped = (s[SW-1:DW-1] != {(SW-DW+1){1'b0}})
            && (s[SW-1:DW-1] != {(SW-DW+1){1'b1}});
      end
   endfunction

   // Register writes; every control resets to disabled or to code zero.
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         left_sidetone_to_dac_gain <= `DMX_GAIN_RESET;
         right_sidetone_to_dac_gain <= `DMX_GAIN_RESET;
         left_sidetone_to_sec_tx_gain <= `DMX_GAIN_RESET;
         right_sidetone_to_sec_tx_gain <= `DMX_GAIN_RESET;
         dac_left_routing <= `DMX_ROUTING_RESET;
         dac_right_routing <= `DMX_ROUTING_RESET;
         sec_tx_left_routing <= `DMX_ROUTING_RESET;
         sec_tx_right_routing <= `DMX_ROUTING_RESET;
         left_capture_to_primary_tx_en <= 1'b0;
         secondary_left_to_primary_tx_en <= 1'b0;
         right_capture_to_primary_tx_en <= 1'b0;
         secondary_right_to_primary_tx_en <= 1'b0;
         sidetone_dc_filter_en <= 1'b0;
         sidetone_filter_cutoff <= 3'h0;
         left_converter_enable <= 1'b0;
         right_converter_enable <= 1'b0;
         core_clock_source_sel <= 1'b0;
      end else if (reg_write) begin
         case (reg_addr)
            `DMX_OFS_DAC_ST_GAIN: begin
               right_sidetone_to_dac_gain <= reg_wdata[`DMX_RIGHT_GAIN_MSB:`DMX_RIGHT_GAIN_LSB];
               left_sidetone_to_dac_gain <= reg_wdata[`DMX_LEFT_GAIN_MSB:`DMX_LEFT_GAIN_LSB];
            end
            `DMX_OFS_SEC_TX_ST_GAIN: begin
               right_sidetone_to_sec_tx_gain <= reg_wdata[`DMX_RIGHT_GAIN_MSB:`DMX_RIGHT_GAIN_LSB];
               left_sidetone_to_sec_tx_gain <= reg_wdata[`DMX_LEFT_GAIN_MSB:`DMX_LEFT_GAIN_LSB];
            end
            `DMX_OFS_DAC_LEFT_ROUTING: dac_left_routing <= reg_wdata[5:0];
            `DMX_OFS_DAC_RIGHT_ROUTING: dac_right_routing <= reg_wdata[5:0];
            `DMX_OFS_SEC_TX_LEFT_ROUTING: sec_tx_left_routing <= reg_wdata[5:0];
            `DMX_OFS_SEC_TX_RIGHT_ROUTING: sec_tx_right_routing <= reg_wdata[5:0];
            `DMX_OFS_PRI_TX_LEFT_ROUTING: begin
               left_capture_to_primary_tx_en <= reg_wdata[`DMX_BIT_CAPTURE_EN];
               secondary_left_to_primary_tx_en <= reg_wdata[`DMX_BIT_SEC_TO_PRI_EN];
            end
            `DMX_OFS_PRI_TX_RIGHT_ROUTING: begin
               right_capture_to_primary_tx_en <= reg_wdata[`DMX_BIT_CAPTURE_EN];
               secondary_right_to_primary_tx_en <= reg_wdata[`DMX_BIT_SEC_TO_PRI_EN];
            end
            `DMX_OFS_SIDETONE_FILTER: begin
               sidetone_dc_filter_en <= reg_wdata[`DMX_BIT_HPF_EN];
               sidetone_filter_cutoff <= reg_wdata[`DMX_CUT_MSB:`DMX_CUT_LSB];
            end
            `DMX_OFS_CAPTURE_CONFIG: begin
               left_converter_enable <= reg_wdata[`DMX_BIT_LEFT_CONV_EN];
               right_converter_enable <= reg_wdata[`DMX_BIT_RIGHT_CONV_EN];
               core_clock_source_sel <= reg_wdata[`DMX_BIT_CLK_SRC];
            end
            default: begin
            end
         endcase
      end
   end

   // Read decode; unmapped offsets and reserved bits read as zero.
   always @* begin
      next_rdata = 16'h0000;
      case (reg_addr)
         `DMX_OFS_DAC_ST_GAIN: begin
            next_rdata[`DMX_RIGHT_GAIN_MSB:`DMX_RIGHT_GAIN_LSB] = right_sidetone_to_dac_gain;
            next_rdata[`DMX_LEFT_GAIN_MSB:`DMX_LEFT_GAIN_LSB] = left_sidetone_to_dac_gain;
         end
         `DMX_OFS_SEC_TX_ST_GAIN: begin
            next_rdata[`DMX_RIGHT_GAIN_MSB:`DMX_RIGHT_GAIN_LSB] = right_sidetone_to_sec_tx_gain;
            next_rdata[`DMX_LEFT_GAIN_MSB:`DMX_LEFT_GAIN_LSB] = left_sidetone_to_sec_tx_gain;
         end
         `DMX_OFS_DAC_LEFT_ROUTING: next_rdata[5:0] = dac_left_routing & 6'h35;
         `DMX_OFS_DAC_RIGHT_ROUTING: next_rdata[5:0] = dac_right_routing & 6'h35;
         `DMX_OFS_SEC_TX_LEFT_ROUTING: next_rdata[5:0] = sec_tx_left_routing & 6'h35;
         `DMX_OFS_SEC_TX_RIGHT_ROUTING: next_rdata[5:0] = sec_tx_right_routing & 6'h35;
         `DMX_OFS_PRI_TX_LEFT_ROUTING: begin
            next_rdata[`DMX_BIT_CAPTURE_EN] = left_capture_to_primary_tx_en;
            next_rdata[`DMX_BIT_SEC_TO_PRI_EN] = secondary_left_to_primary_tx_en;
         end
         `DMX_OFS_PRI_TX_RIGHT_ROUTING: begin
            next_rdata[`DMX_BIT_CAPTURE_EN] = right_capture_to_primary_tx_en;
            next_rdata[`DMX_BIT_SEC_TO_PRI_EN] = secondary_right_to_primary_tx_en;
         end
         `DMX_OFS_SIDETONE_FILTER: begin
            next_rdata[`DMX_BIT_HPF_EN] = sidetone_dc_filter_en;
            next_rdata[`DMX_CUT_MSB:`DMX_CUT_LSB] = sidetone_filter_cutoff;
         end
         `DMX_OFS_CAPTURE_CONFIG: begin
            next_rdata[`DMX_BIT_LEFT_CONV_EN] = left_converter_enable;
            next_rdata[`DMX_BIT_RIGHT_CONV_EN] = right_converter_enable;
            next_rdata[`DMX_BIT_CLK_SRC] = core_clock_source_sel;
         end
         `DMX_OFS_CLIP_STATUS: next_rdata[5:0] = clip_status;
         default: next_rdata = 16'h0000;
      endcase
   end

   // Read data stand for exactly the cycle after the read strobe.
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 16'h0000;
      end else if (reg_read) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

   // Capture source: converter data when that converter runs, else microphone.
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         left_capture <= {DW{1'b0}};
         right_capture <= {DW{1'b0}};
      end else begin
         left_capture <= left_converter_enable ? left_adc_data
            : left_digital_microphone_input;
         right_capture <= right_converter_enable ? right_adc_data
            : right_digital_microphone_input;
      end
   end

   // The filter advances at the rate of the port that clocks the core.
   assign filter_step = core_clock_source_sel ? secondary_frame_strobe
      : primary_frame_strobe;

   // One shared enable and cut-off drive both sidetone filters.
   dmx_dc_filter #(.DW(DW)) u_left_filter (
      .clock(clock),
      .resetn(resetn),
      .step(filter_step),
      .enable(sidetone_dc_filter_en),
      .cutoff(sidetone_filter_cutoff),
      .sample_in(left_capture),
      .sample_out(left_sidetone)
   );

   dmx_dc_filter #(.DW(DW)) u_right_filter (
      .clock(clock),
      .resetn(resetn),
      .step(filter_step),
      .enable(sidetone_dc_filter_en),
      .cutoff(sidetone_filter_cutoff),
      .sample_in(right_capture),
      .sample_out(right_sidetone)
   );

   // Sidetone gains towards the DAC mixers.
   dmx_gain #(.DW(DW)) u_left_dac_gain (
      .clock(clock),
      .resetn(resetn),
      .gain_code(left_sidetone_to_dac_gain),
      .sample_in(left_sidetone),
      .sample_out(left_st_dac)
   );

   dmx_gain #(.DW(DW)) u_right_dac_gain (
      .clock(clock),
      .resetn(resetn),
      .gain_code(right_sidetone_to_dac_gain),
      .sample_in(right_sidetone),
      .sample_out(right_st_dac)
   );

   // Sidetone gains towards the secondary transmit mixers.
   dmx_gain #(.DW(DW)) u_left_sec_gain (
      .clock(clock),
      .resetn(resetn),
      .gain_code(left_sidetone_to_sec_tx_gain),
      .sample_in(left_sidetone),
      .sample_out(left_st_sec)
   );

   dmx_gain #(.DW(DW)) u_right_sec_gain (
      .clock(clock),
      .resetn(resetn),
      .gain_code(right_sidetone_to_sec_tx_gain),
      .sample_in(right_sidetone),
      .sample_out(right_st_sec)
   );

   // Mixer sums, wide enough that no sum of four terms can wrap.
   assign sum_pri_l = term(left_capture_to_primary_tx_en, left_capture)
      + term(secondary_left_to_primary_tx_en, secondary_rx_left);
   assign sum_pri_r = term(right_capture_to_primary_tx_en, right_capture)
      + term(secondary_right_to_primary_tx_en, secondary_rx_right);
   assign sum_dac_l = mix4(dac_left_routing, primary_rx_left, secondary_rx_left,
      left_st_dac, right_st_dac);
   assign sum_dac_r = mix4(dac_right_routing, primary_rx_right, secondary_rx_right,
      left_st_dac, right_st_dac);
   assign sum_sec_l = mix4(sec_tx_left_routing, primary_rx_left, secondary_rx_left,
      left_st_sec, right_st_sec);
   assign sum_sec_r = mix4(sec_tx_right_routing, primary_rx_right, secondary_rx_right,
      left_st_sec, right_st_sec);

   // Mixer outputs are limited to full scale.
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         primary_tx_left <= {DW{1'b0}};
         primary_tx_right <= {DW{1'b0}};
         dac_left <= {DW{1'b0}};
         dac_right <= {DW{1'b0}};
         secondary_tx_left <= {DW{1'b0}};
         secondary_tx_right <= {DW{1'b0}};
      end else begin
         primary_tx_left <= sat(sum_pri_l);
         primary_tx_right <= sat(sum_pri_r);
         dac_left <= sat(sum_dac_l);
         dac_right <= sat(sum_dac_r);
         secondary_tx_left <= sat(sum_sec_l);
         secondary_tx_right <= sat(sum_sec_r);
      end
   end

   // Sticky clip flags; writing one clears a flag, a new clip wins.
   assign clip_now = {clipped(sum_sec_r), clipped(sum_sec_l), clipped(sum_dac_r),
      clipped(sum_dac_l), clipped(sum_pri_r), clipped(sum_pri_l)};
   assign wr_clip = reg_write && (reg_addr == `DMX_OFS_CLIP_STATUS);
   assign clip_clear = wr_clip ? reg_wdata[5:0] : 6'h00;

   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         clip_status <= 6'h00;
      end else begin
         clip_status <= (clip_status & ~clip_clear) | clip_now;
      end
   end
endmodule
`default_nettype wire

// [verif/dmx_mixer_chk.sv]
`timescale 1ns/10ps
`default_nettype none
module dmx_mixer_chk #(
   parameter DW = 24
) (
   input wire clock,
   input wire resetn,
   input wire [11:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   input wire [15:0] reg_rdata,
   input wire signed [DW-1:0] left_adc_data,
   input wire signed [DW-1:0] left_digital_microphone_input,
   input wire signed [DW-1:0] secondary_rx_left,
   input wire signed [DW-1:0] secondary_rx_right,
   input wire signed [DW-1:0] primary_tx_left,
   input wire signed [DW-1:0] primary_tx_right,
   input wire signed [DW-1:0] dac_left
);
   logic [1:0] rl;
   logic [1:0] rr;
   logic [5:0] rd;
   logic [3:0] gl;
   logic hpf;
   logic cvl;
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   // Shadow copies of the configuration bits that the properties depend on.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rl <= 2'h0;
         rr <= 2'h0;
         rd <= 6'h00;
         gl <= 4'h0;
         hpf <= 1'b0;
         cvl <= 1'b0;
      end else if (reg_write) begin
         case (reg_addr)
            12'h600: gl <= reg_wdata[3:0];
            12'h601: rd <= reg_wdata[5:0];
            12'h606: rl <= reg_wdata[1:0];
            12'h607: rr <= reg_wdata[1:0];
            12'h621: hpf <= reg_wdata[6];
            12'h622: cvl <= reg_wdata[0];
            default: ;
         endcase
      end
   end
   // Stable routing windows that cover each path's pipeline depth.
   sequence s_sec_l; (rl == 2'h1)[*2]; endsequence
   sequence s_sec_r; (rr == 2'h1)[*2]; endsequence
   sequence s_cap_l(bit c); (rl == 2'h2 && cvl == c)[*3]; endsequence
   sequence s_st_l; (rd == 6'h10 && gl >= 4'hC && !hpf && cvl)[*5]; endsequence
   property p_rst; $rose(resetn) |-> primary_tx_left == 0 && dac_left == 0; endproperty
   property p_rb_l; $past(reg_read && reg_addr == 12'h606) |-> reg_rdata == {14'h0, $past(rl)};
   endproperty
   property p_rb_r; $past(reg_read && reg_addr == 12'h607) |-> reg_rdata == {14'h0, $past(rr)};
   endproperty
   property p_sec_l; s_sec_l |-> primary_tx_left == $past(secondary_rx_left); endproperty
   property p_sec_r; s_sec_r |-> primary_tx_right == $past(secondary_rx_right); endproperty
   property p_adc_l; s_cap_l(1'b1) |-> primary_tx_left == $past(left_adc_data, 2); endproperty
   property p_mic_l;
      s_cap_l(1'b0) |-> primary_tx_left == $past(left_digital_microphone_input, 2);
   endproperty
   property p_st_l; s_st_l |-> dac_left == $past(left_adc_data, 4); endproperty
   property p_dac_off; (rd == 6'h00)[*2] |-> dac_left == 0; endproperty
   a_rst: assert property (p_rst) else $error("outputs not zero after reset");
   a_rb_l: assert property (p_rb_l) else $error("left routing readback wrong");
   a_rb_r: assert property (p_rb_r) else $error("right routing readback wrong");
   a_sec_l: assert property (p_sec_l) else $error("left secondary term wrong");
   a_sec_r: assert property (p_sec_r) else $error("right secondary term wrong");
   a_adc_l: assert property (p_adc_l) else $error("left converter term wrong");
   a_mic_l: assert property (p_mic_l) else $error("left microphone term wrong");
   a_st_l: assert property (p_st_l) else $error("left sidetone to dac wrong");
   a_dac_off: assert property (p_dac_off) else $error("dac not silent");
endmodule
bind dmx_mixer dmx_mixer_chk #(.DW(DW)) dmx_mixer_chk_inst (.clock(clock), .resetn(resetn),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
   .reg_rdata(reg_rdata), .left_adc_data(left_adc_data),
   .left_digital_microphone_input(left_digital_microphone_input),
   .secondary_rx_left(secondary_rx_left), .secondary_rx_right(secondary_rx_right),
   .primary_tx_left(primary_tx_left), .primary_tx_right(primary_tx_right), .dac_left(dac_left));
`default_nettype wire

// [verif/digital_mixer_sidetone_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module digital_mixer_sidetone_bench;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [15:0] reg_rdata;
   logic ps = 1'b0;
   logic ss = 1'b0;
   logic signed [23:0] adc_l = 0, adc_r = 0, mic_l = 0, mic_r = 0, srx_l = 0, srx_r = 0;
   logic signed [23:0] ptx_l, ptx_r, dac_l, dac_r, stx_l, stx_r;
   int fail_count = 0;
   int n_checks = 0;
   logic [11:0] ra [5] = '{12'h600, 12'h603, 12'h606, 12'h607, 12'h621};
   logic [15:0] rm [5] = '{16'h01EF, 16'h01EF, 16'h0003, 16'h0003, 16'h03C0};
   logic signed [23:0] va [3] = '{24'h100000, 24'h7FFFFF, 24'h800000};
   logic signed [23:0] vs [3] = '{24'h023456, 24'h000010, 24'hFFFFF0};
   logic signed [23:0] ve [3] = '{24'h123456, 24'h7FFFFF, 24'h800000};
   dmx_mixer dmx_mixer_inst (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .primary_frame_strobe(ps), .secondary_frame_strobe(ss), .left_adc_data(adc_l),
      .right_adc_data(adc_r), .left_digital_microphone_input(mic_l),
      .right_digital_microphone_input(mic_r), .primary_rx_left(24'sh0),
      .primary_rx_right(24'sh0), .secondary_rx_left(srx_l), .secondary_rx_right(srx_r),
      .primary_tx_left(ptx_l), .primary_tx_right(ptx_r), .dac_left(dac_l), .dac_right(dac_r),
      .secondary_tx_left(stx_l), .secondary_tx_right(stx_r));
   // The clock toggles every half period of 12.5 ns.
   always #12.5 clock = ~clock;
   // Counts every compare and reports a mismatch at once.
   task automatic chk(input [23:0] s, input [23:0] e);
      n_checks++;
      if (s !== e) begin
         fail_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // One-cycle write strobe, then a quiet cycle so strobes never collide.
   task automatic wr(input [11:0] a, input [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
      @(posedge clock);
   endtask
   // Read data stand only in the cycle after the strobe.
   task automatic rd(input [11:0] a, input [15:0] e);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 chk({8'h00, reg_rdata}, {8'h00, e});
      @(posedge clock);
   endtask
   // Frame strobes of one cycle each, on the chosen port.
   task automatic pul(input bit sec, input int n);
      repeat (n) begin
         if (sec) ss <= 1'b1;
         else ps <= 1'b1;
         @(posedge clock);
         ss <= 1'b0;
         ps <= 1'b0;
         @(posedge clock);
      end
   endtask
   task automatic settle();
      repeat (6) @(posedge clock);
      #1;
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Main sequence of register and datapath tests.
   initial begin
      repeat (20) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      for (int i = 0; i < 5; i++) begin
         rd(ra[i], 16'h0000);
         wr(ra[i], 16'hFFFF);
         rd(ra[i], rm[i]);
         wr(ra[i], 16'h0000);
      end
      wr(12'h6FF, 16'hFFFF);
      rd(12'h6FF, 16'h0000);
      $display("test registers done");
      wr(12'h622, 16'h0003);
      wr(12'h606, 16'h0003);
      wr(12'h607, 16'h0003);
      for (int i = 0; i < 3; i++) begin
         adc_l <= va[i];
         adc_r <= va[i];
         srx_l <= vs[i];
         srx_r <= vs[i];
         settle();
         chk(ptx_l, ve[i]);
         chk(ptx_r, ve[i]);
         @(posedge clock);
      end
      wr(12'h606, 16'h0001);
      wr(12'h607, 16'h0001);
      settle();
      chk(ptx_l, 24'hFFFFF0);
      chk(ptx_r, 24'hFFFFF0);
      @(posedge clock);
      wr(12'h622, 16'h0000);
      wr(12'h606, 16'h0002);
      wr(12'h607, 16'h0002);
      mic_l <= 24'h0F0F0F;
      mic_r <= 24'h070707;
      settle();
      chk(ptx_l, 24'h0F0F0F);
      chk(ptx_r, 24'h070707);
      $display("test transmit mix done");
      @(posedge clock);
      adc_l <= 24'h123456;
      adc_r <= 24'h0ABCDE;
      wr(12'h622, 16'h0003);
      wr(12'h600, 16'h018F);
      wr(12'h601, 16'h0010);
      wr(12'h602, 16'h0020);
      wr(12'h603, 16'h01EC);
      wr(12'h604, 16'h0030);
      wr(12'h605, 16'h0010);
      settle();
      chk(dac_l, 24'h123456);
      chk(dac_r, 24'h0ABCDE);
      chk(stx_l, 24'h1CF134);
      chk(stx_r, 24'h123456);
      @(posedge clock);
      wr(12'h600, 16'h0000);
      settle();
      chk({23'h0, dac_l > 24'sh0048D1 && dac_l < 24'sh0091A2}, 24'h1);
      $display("test sidetone gain done");
      @(posedge clock);
      adc_l <= 24'h100000;
      adc_r <= 24'h100000;
      wr(12'h600, 16'h018F);
      wr(12'h622, 16'h0007);
      wr(12'h621, 16'h0040);
      pul(1'b1, 1);
      pul(1'b0, 20);
      settle();
      chk({23'h0, dac_l > 24'sh080000}, 24'h1);
      chk({23'h0, dac_r > 24'sh080000}, 24'h1);
      @(posedge clock);
      pul(1'b1, 40);
      settle();
      chk({23'h0, dac_l < 24'sh010000 && dac_l > -24'sh010000}, 24'h1);
      @(posedge clock);
      // A disabled step with zero input clears the filter, then a new step starts.
      adc_l <= 24'h000000;
      wr(12'h621, 16'h0000);
      pul(1'b1, 1);
      adc_l <= 24'h100000;
      wr(12'h621, 16'h0340);
      pul(1'b1, 8);
      settle();
      chk({23'h0, dac_l > 24'sh080000}, 24'h1);
      $display("test sidetone filter done");
      complete_run();
   end
   // Watchdog, far beyond the few hundred cycles the tests need.
   initial begin
      repeat (20000) @(posedge clock);
      fail_count++;
      complete_run();
   end
endmodule
`default_nettype wire
